//--- inc/lbc_defines.svh
// register offsets, reset values, field positions and timing counts for the indicator/converter bank
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LBC_ADDR_IND1_ON_TIME   8'h08
`define LBC_ADDR_IND1_PERIOD    8'h09
`define LBC_ADDR_IND2_ON_TIME   8'h0A
`define LBC_ADDR_IND2_PERIOD    8'h0B
`define LBC_ADDR_MAIN_CTRL      8'h0C
`define LBC_ADDR_CORE_CTRL      8'h0D
`define LBC_ADDR_LINREG_CTRL    8'h0E

// ---------------------------------------------------------------
// reset values (strap bits are merged in at reset)
// ---------------------------------------------------------------
`define LBC_RST_IND             8'h00
`define LBC_RST_MAIN_CTRL       8'h32
`define LBC_RST_CORE_CTRL       8'h68
`define LBC_RST_LINREG_CTRL     8'h88
`define LBC_RD_UNMAPPED         8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LBC_MODE_BIT            7
`define LBC_MAIN_FORCED_FIXED_FREQ           7
`define LBC_MAIN_UVLO_HI        6
`define LBC_MAIN_UVLO_LO        5
`define LBC_MAIN_SUPPLY_SEL     4
`define LBC_MAIN_LP_EN          3
`define LBC_MAIN_DISCHARGE      2
`define LBC_MAIN_VOLT_HI        1
`define LBC_MAIN_VOLT_LO        0
`define LBC_CORE_OFF_LP         7
`define LBC_CORE_VOLT_HI        6
`define LBC_CORE_VOLT_LO        4
`define LBC_CORE_LP_HI          3
`define LBC_CORE_LP_LO          2
`define LBC_CORE_VIB            1
`define LBC_CORE_DISCHARGE      0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LBC_CLK_MHZ             125
`define LBC_TICK_US             10000
`define LBC_ON_STEP_TICKS       1
`define LBC_PER_STEP_TICKS      10

`endif

//--- inc/lbc_pkg.sv
// types shared by the indicator/converter control bank
package lbc_pkg;
   typedef enum logic [1:0] {
      LBC_IND_OFF,
      LBC_IND_BLINK,
      LBC_IND_ON,
      LBC_IND_CHARGER
   } lbc_ind_sel_t;

   // wide enough for the longest period: 128 steps of 10 ticks
   typedef logic [10:0] lbc_ticks_t;
endpackage

//--- inc/lbc_blink_if.sv
// carrier between the control bank and one blink timer
`timescale 1ns/1ps
interface lbc_blink_if;
   logic       tick;
   logic       blink_en;
   logic [6:0] on_time;
   logic [6:0] period;
   logic       lit;

   modport ctrl  (output tick, output blink_en, output on_time, output period, input lit);
   modport timer (input tick, input blink_en, input on_time, input period, output lit);
endinterface

//--- src/lbc_blink.sv
// blink timer for one open-drain indicator, counted in 10 ms ticks
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_blink
   import lbc_pkg::*;
(
   input  wire logic   i_sys_clk,
   input  wire logic   i_sys_rst,
   lbc_blink_if.timer  bl
);
   // code 0 means one step, so every code adds one
   function automatic lbc_ticks_t steps_to_ticks(input logic [6:0] code,
                                                  input logic [3:0] step);
      steps_to_ticks = lbc_ticks_t'(({4'h0, code} + 11'h001) * {7'h00, step});
   endfunction

   lbc_ticks_t cnt;
   lbc_ticks_t next_cnt;
   wire lbc_ticks_t on_len  = steps_to_ticks(bl.on_time, 4'(`LBC_ON_STEP_TICKS));
   wire lbc_ticks_t per_len = steps_to_ticks(bl.period, 4'(`LBC_PER_STEP_TICKS));
   wire             wrap    = (cnt >= per_len - 11'h001);
   wire             next_lit = bl.blink_en && (cnt < on_len);

   // ---------------------------------------------------------------
   // period counter
   // ---------------------------------------------------------------
   always_comb begin
      next_cnt = cnt;
      if (!bl.blink_en)
         next_cnt = '0;
      else if (bl.tick)
         next_cnt = wrap ? '0 : cnt + 11'h001;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cnt    <= '0;
         bl.lit <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         bl.lit <= next_lit;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   blink_gate_a: assert property (!bl.blink_en |=> !bl.lit)
      else $error("indicator lit while blinking disabled");
   blink_start_a: assert property (bl.blink_en && cnt == 11'h000 |=> bl.lit)
      else $error("indicator dark at start of blink period");
   blink_bound_a: assert property (bl.blink_en && cnt >= on_len |=> !bl.lit)
      else $error("indicator lit past on-time");
   blink_wrap_a: assert property (bl.blink_en && bl.tick && wrap |=> cnt == 11'h000)
      else $error("blink period did not wrap");
endmodule

//--- src/lbc_ctrl.sv
// indicator blink and step-down converter control bank
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_ctrl
   import lbc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `LBC_TICK_US * `LBC_CLK_MHZ
)
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_sys_rst,
   // register port from the serial interface
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_wr,
   output logic      [7:0] o_reg_rdata,
   // charger side
   input  wire logic       i_ac_valid,
   input  wire logic       i_usb_valid,
   input  wire logic       i_charge_enable,
   input  wire logic       i_usb_charge_allowed,
   input  wire logic       i_charger_status_on,
   output logic            o_charge_from_ac,
   output logic            o_charge_from_usb,
   // open-drain indicators
   output logic            o_charge_status_out,
   output logic            o_charge_status_oe,
   output logic            o_indicator2_out,
   output logic            o_indicator2_oe,
   // pins and straps
   input  wire logic       i_low_power_request_pin,
   input  wire logic       i_main_default_strap,
   input  wire logic       i_core_default_strap,
   // converter control
   output logic            o_forced_fixed_freq,
   output logic      [1:0] o_undervoltage_thresh_code,
   output logic            o_low_power_mode,
   output logic            o_wait_mode,
   output logic            o_main_rail_en,
   output logic            o_main_rail_discharge,
   output logic      [1:0] o_main_rail_code,
   output logic            o_core_rail_en,
   output logic            o_core_rail_discharge,
   output logic      [2:0] o_core_rail_code,
   output logic            o_vibrator_drive
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // no reset on these: straps must be settled while reset is held
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;

   always_ff @(posedge i_sys_clk) begin
      pin_meta <= {i_ac_valid, i_usb_valid, i_low_power_request_pin,
                   i_main_default_strap, i_core_default_strap};
      pin_sync <= pin_meta;
   end

   wire ac_s        = pin_sync[4];
   wire usb_s       = pin_sync[3];
   wire lp_pin_s    = pin_sync[2];
   wire main_strap  = pin_sync[1];
   wire core_strap  = pin_sync[0];

   // charger status comes from on-chip logic on this clock
   wire chg_stat    = i_charger_status_on;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [7:0] ind1_on_time;
   logic [7:0] ind1_period;
   logic [7:0] ind2_on_time;
   logic [7:0] ind2_period;
   logic [7:0] main_converter_ctrl;
   logic [7:0] core_converter_ctrl;
   logic [7:0] linear_regulator_ctrl;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   wire wr_i1on  = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_IND1_ON_TIME);
   wire wr_i1per = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_IND1_PERIOD);
   wire wr_i2on  = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_IND2_ON_TIME);
   wire wr_i2per = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_IND2_PERIOD);
   wire wr_main  = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_MAIN_CTRL);
   wire wr_core  = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_CORE_CTRL);
   wire wr_lin   = i_reg_wr && hit(i_reg_addr, `LBC_ADDR_LINREG_CTRL);

   // strap levels land in the low code bits on every clock edge while reset is held
   wire [7:0] main_rst = `LBC_RST_MAIN_CTRL | {7'h00, main_strap};
   wire [7:0] core_rst = `LBC_RST_CORE_CTRL | {3'h0, core_strap, 4'h0};

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ind1_on_time          <= `LBC_RST_IND;
         ind1_period           <= `LBC_RST_IND;
         ind2_on_time          <= `LBC_RST_IND;
         ind2_period           <= `LBC_RST_IND;
         main_converter_ctrl   <= main_rst;
         core_converter_ctrl   <= core_rst;
         linear_regulator_ctrl <= `LBC_RST_LINREG_CTRL;
      end else begin
         if (wr_i1on)  ind1_on_time          <= i_reg_wdata;
         if (wr_i1per) ind1_period           <= i_reg_wdata;
         if (wr_i2on)  ind2_on_time          <= i_reg_wdata;
         if (wr_i2per) ind2_period           <= i_reg_wdata;
         if (wr_main)  main_converter_ctrl   <= i_reg_wdata;
         if (wr_core)  core_converter_ctrl   <= i_reg_wdata;
         if (wr_lin)   linear_regulator_ctrl <= i_reg_wdata;
      end
   end

   logic [7:0] next_rdata;
   always_comb begin
      unique case (i_reg_addr)
         `LBC_ADDR_IND1_ON_TIME: next_rdata = ind1_on_time;
         `LBC_ADDR_IND1_PERIOD:  next_rdata = ind1_period;
         `LBC_ADDR_IND2_ON_TIME: next_rdata = ind2_on_time;
         `LBC_ADDR_IND2_PERIOD:  next_rdata = ind2_period;
         `LBC_ADDR_MAIN_CTRL:    next_rdata = main_converter_ctrl;
         `LBC_ADDR_CORE_CTRL:    next_rdata = core_converter_ctrl;
         `LBC_ADDR_LINREG_CTRL:  next_rdata = linear_regulator_ctrl;
         default:                next_rdata = `LBC_RD_UNMAPPED;
      endcase
   end

   // ---------------------------------------------------------------
   // field decode
   // ---------------------------------------------------------------
   wire       ind1_mode_hi          = ind1_on_time[`LBC_MODE_BIT];
   wire       ind1_mode_lo          = ind1_period[`LBC_MODE_BIT];
   wire       ind2_mode_hi          = ind2_on_time[`LBC_MODE_BIT];
   wire       ind2_mode_lo          = ind2_period[`LBC_MODE_BIT];
   wire       forced_fixed_freq     = main_converter_ctrl[`LBC_MAIN_FORCED_FIXED_FREQ];
   wire [1:0] undervoltage_code     =
      main_converter_ctrl[`LBC_MAIN_UVLO_HI:`LBC_MAIN_UVLO_LO];
   wire       supply_sel            = main_converter_ctrl[`LBC_MAIN_SUPPLY_SEL];
   wire       low_power_pin_enable  = main_converter_ctrl[`LBC_MAIN_LP_EN];
   wire       main_discharge_bit    = main_converter_ctrl[`LBC_MAIN_DISCHARGE];
   wire [1:0] main_code             =
      main_converter_ctrl[`LBC_MAIN_VOLT_HI:`LBC_MAIN_VOLT_LO];
   wire       core_off_in_low_power = core_converter_ctrl[`LBC_CORE_OFF_LP];
   wire [2:0] core_code             =
      core_converter_ctrl[`LBC_CORE_VOLT_HI:`LBC_CORE_VOLT_LO];
   wire [1:0] core_low_power_code   =
      core_converter_ctrl[`LBC_CORE_LP_HI:`LBC_CORE_LP_LO];
   wire       vibrator_bit          = core_converter_ctrl[`LBC_CORE_VIB];
   wire       core_discharge_bit    = core_converter_ctrl[`LBC_CORE_DISCHARGE];

   // indicator 1 may hand the pin back to the charger; indicator 2 never does
   function automatic lbc_ind_sel_t ind_sel(input logic hi, input logic lo,
                                             input logic charger_allowed);
      unique case ({hi, lo})
         2'b00:   ind_sel = charger_allowed ? LBC_IND_CHARGER : LBC_IND_OFF;
         2'b01:   ind_sel = LBC_IND_BLINK;
         2'b10:   ind_sel = LBC_IND_OFF;
         2'b11:   ind_sel = LBC_IND_ON;
      endcase
   endfunction

   wire lbc_ind_sel_t ind1_sel = ind_sel(ind1_mode_hi, ind1_mode_lo, 1'b1);
   wire lbc_ind_sel_t ind2_sel = ind_sel(ind2_mode_hi, ind2_mode_lo, 1'b0);

   // ---------------------------------------------------------------
   // 10 ms tick and blink timers
   // ---------------------------------------------------------------
   logic [20:0] tick_cnt;
   logic        tick;
   wire         tick_wrap = (tick_cnt == 21'(TICK_CYCLES - 1));

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 21'h000001;
         tick     <= tick_wrap;
      end
   end

   lbc_blink_if bl1 ();
   lbc_blink_if bl2 ();

   assign bl1.tick     = tick;
   assign bl1.blink_en = (ind1_sel == LBC_IND_BLINK);
   assign bl1.on_time  = ind1_on_time[6:0];
   assign bl1.period   = ind1_period[6:0];
   assign bl2.tick     = tick;
   assign bl2.blink_en = (ind2_sel == LBC_IND_BLINK);
   assign bl2.on_time  = ind2_on_time[6:0];
   assign bl2.period   = ind2_period[6:0];

   lbc_blink u_blink1 (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .bl        (bl1.timer)
   );

   lbc_blink u_blink2 (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .bl        (bl2.timer)
   );

   // ---------------------------------------------------------------
   // output decode
   // ---------------------------------------------------------------
   function automatic logic ind_drive(input lbc_ind_sel_t sel, input logic lit,
                                      input logic chg);
      unique case (sel)
         LBC_IND_OFF:     ind_drive = 1'b0;
         LBC_IND_BLINK:   ind_drive = lit;
         LBC_IND_ON:      ind_drive = 1'b1;
         LBC_IND_CHARGER: ind_drive = chg;
      endcase
   endfunction

   wire next_ind1_oe = ind_drive(ind1_sel, bl1.lit, chg_stat);
   wire next_ind2_oe = ind_drive(ind2_sel, bl2.lit, 1'b0);

   wire next_from_ac  = i_charge_enable && ac_s;
   wire next_from_usb = i_charge_enable && i_usb_charge_allowed && usb_s && !ac_s;

   wire lp_active      = lp_pin_s && low_power_pin_enable;
   wire next_lp_mode   = lp_active && supply_sel;
   wire next_wait_mode = lp_active && !supply_sel;
   wire next_main_en   = !next_wait_mode;
   wire core_lp_off    = next_lp_mode && core_off_in_low_power;
   wire next_core_en   = !next_wait_mode && !core_lp_off;
   wire next_main_dis  = main_discharge_bit && !next_main_en;
   wire next_core_dis  = core_discharge_bit && (next_wait_mode || core_lp_off);
   // low-power code only while in low-power; leaving restores the normal code
   wire [2:0] next_core_code = next_lp_mode ? {1'b0, core_low_power_code} : core_code;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata                <= `LBC_RD_UNMAPPED;
         o_charge_from_ac           <= 1'b0;
         o_charge_from_usb          <= 1'b0;
         o_charge_status_out        <= 1'b0;
         o_charge_status_oe         <= 1'b0;
         o_indicator2_out           <= 1'b0;
         o_indicator2_oe            <= 1'b0;
         o_forced_fixed_freq        <= 1'b0;
         o_undervoltage_thresh_code <= 2'h0;
         o_low_power_mode           <= 1'b0;
         o_wait_mode                <= 1'b0;
         o_main_rail_en             <= 1'b1;
         o_main_rail_discharge      <= 1'b0;
         o_main_rail_code           <= 2'h0;
         o_core_rail_en             <= 1'b1;
         o_core_rail_discharge      <= 1'b0;
         o_core_rail_code           <= 3'h0;
         o_vibrator_drive           <= 1'b0;
      end else begin
         o_reg_rdata                <= next_rdata;
         o_charge_from_ac           <= next_from_ac;
         o_charge_from_usb          <= next_from_usb;
         o_charge_status_out        <= 1'b0;
         o_charge_status_oe         <= next_ind1_oe;
         o_indicator2_out           <= 1'b0;
         o_indicator2_oe            <= next_ind2_oe;
         o_forced_fixed_freq        <= forced_fixed_freq;
         o_undervoltage_thresh_code <= undervoltage_code;
         o_low_power_mode           <= next_lp_mode;
         o_wait_mode                <= next_wait_mode;
         o_main_rail_en             <= next_main_en;
         o_main_rail_discharge      <= next_main_dis;
         o_main_rail_code           <= main_code;
         o_core_rail_en             <= next_core_en;
         o_core_rail_discharge      <= next_core_dis;
         o_core_rail_code           <= next_core_code;
         o_vibrator_drive           <= vibrator_bit;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   ac_priority_a: assert property (
      i_charge_enable && i_usb_charge_allowed && ac_s && usb_s
      |=> o_charge_from_ac && !o_charge_from_usb)
      else $error("adapter not preferred with both inputs valid");
   no_charge_a: assert property (
      !i_charge_enable |=> !o_charge_from_ac && !o_charge_from_usb)
      else $error("charging while charge enable is low");
   ind1_charger_a: assert property (
      !ind1_mode_hi && !ind1_mode_lo |=> o_charge_status_oe == $past(chg_stat))
      else $error("status pin not following charger in mode 00");
   ind1_force_a: assert property (
      ind1_mode_hi |=> o_charge_status_oe == $past(ind1_mode_lo))
      else $error("indicator 1 forced mode wrong");
   ind2_mode_a: assert property (
      !ind2_mode_lo ##1 !ind2_mode_lo |-> !o_indicator2_oe)
      else $error("indicator 2 on in an off mode");
   fixed_freq_a: assert property (
      $changed(forced_fixed_freq) |=> o_forced_fixed_freq == $past(forced_fixed_freq))
      else $error("forced fixed-frequency output lags");
   uvlo_code_a: assert property (
      1'b1 |=> o_undervoltage_thresh_code == $past(undervoltage_code))
      else $error("undervoltage code not passed through");
   lp_select_a: assert property (
      lp_pin_s && low_power_pin_enable
      |=> o_low_power_mode == $past(supply_sel) && o_wait_mode != $past(supply_sel))
      else $error("wrong low-power state selected");
   lp_ignore_a: assert property (
      !low_power_pin_enable |=> !o_low_power_mode && !o_wait_mode)
      else $error("request pin acted while disabled");
   main_dis_a: assert property (
      o_main_rail_discharge |-> !o_main_rail_en)
      else $error("main discharge while main converter enabled");
   core_off_a: assert property (
      o_low_power_mode |-> o_core_rail_en == !$past(core_off_in_low_power))
      else $error("core enable wrong in low-power mode");
   core_lp_code_a: assert property (
      o_low_power_mode |-> o_core_rail_code == {1'b0, $past(core_low_power_code)})
      else $error("core low-power code not applied");
   core_exit_a: assert property (
      $fell(o_low_power_mode) |-> o_core_rail_code == $past(core_code))
      else $error("core code not restored on exit");
   vib_a: assert property (
      1'b1 |=> o_vibrator_drive == $past(vibrator_bit))
      else $error("vibrator drive does not follow its bit");
   core_dis_a: assert property (
      o_core_rail_discharge |-> !o_core_rail_en && $past(core_discharge_bit))
      else $error("core discharge at wrong time");
   tick_gap_a: assert property (
      tick |=> !tick)
      else $error("tick wider than one cycle");
endmodule

//--- verification/lbc_host_model.sv
// host model driving the register port of the control bank
`timescale 1ns/1ps
module lbc_host_model (
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_reg_rdata,
   output logic      [7:0] o_reg_addr = 8'h00,
   output logic      [7:0] o_reg_wdata = 8'h00,
   output logic            o_reg_wr = 1'b0
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk) #1;
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(posedge i_sys_clk) #1;
      o_reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk) #1;
      o_reg_addr = a;
      @(posedge i_sys_clk) #1;
      d = i_reg_rdata;
   endtask
endmodule

//--- verification/tb_lbc_ctrl.sv
// self-checking bench for the indicator and converter control bank
`timescale 1ns/1ps
module tb_lbc_ctrl;
   logic i_sys_clk = 0, i_sys_rst = 1, i_reg_wr, i_charge_enable = 0, i_usb_charge_allowed = 1;
   logic i_ac_valid = 1, i_usb_valid = 1, i_charger_status_on = 1, i_low_power_request_pin = 0;
   logic i_main_default_strap = 1, i_core_default_strap = 1, o_charge_from_ac, o_charge_from_usb;
   logic o_charge_status_out, o_charge_status_oe, o_indicator2_out, o_indicator2_oe, o_wait_mode;
   logic o_forced_fixed_freq, o_low_power_mode, o_main_rail_en, o_main_rail_discharge;
   logic o_core_rail_en, o_core_rail_discharge, o_vibrator_drive;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rdv;
   logic [1:0] o_undervoltage_thresh_code, o_main_rail_code;
   logic [2:0] o_core_rail_code;
   int err_count = 0, total_checks = 0, cyc = 0, h1 = 0, h2 = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   lbc_ctrl #(.TICK_CYCLES(4)) dut (.*);
   lbc_host_model host (.i_sys_clk(i_sys_clk), .i_reg_rdata(o_reg_rdata),
      .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .o_reg_wr(i_reg_wr));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      err_count += int'(seen !== exp);
      if (seen !== exp)
         $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
   endtask
   task automatic final_report;
      if (err_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      #32;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rdv);
      chk(rdv, e);
   endtask
   task automatic cnt(input int c);
      repeat (c) begin
         @(posedge i_sys_clk) #1;
         h1 += int'(o_charge_status_oe);
         h2 += int'(o_indicator2_oe);
      end
   endtask
   always @(posedge i_sys_clk)
      if (++cyc == 4000) begin
         err_count++;
         final_report;
      end
   initial begin
      repeat (10) @(posedge i_sys_clk);
      #1 i_sys_rst = 0;
      rchk(8'h0C, 8'h33);
      rchk(8'h20, 8'h00);
      chk({o_main_rail_code, o_core_rail_code}, 8'h1F);
      chk({o_charge_from_ac, o_charge_status_oe, o_indicator2_oe}, 8'h02);
      chk({o_charge_status_out, o_indicator2_out}, 8'h00);
      i_charger_status_on = 0;
      #32;
      chk(o_charge_status_oe, 8'h00);
      w(8'h0C, 8'hD9);
      chk({o_forced_fixed_freq, o_undervoltage_thresh_code}, 8'h06);
      for (int c = 0; c < 8; c++) begin
         w(8'h0D, {1'b0, 3'(c), 4'h8});
         chk(o_core_rail_code, 8'(c));
      end
      @(posedge i_sys_clk) #1 i_low_power_request_pin = 1;
      i_charge_enable = 1;
      #32;
      chk({o_low_power_mode, o_core_rail_code, o_core_rail_en}, 8'h15);
      chk({o_charge_from_ac, o_charge_from_usb}, 8'h02);
      i_ac_valid = 0;
      #32;
      chk({o_charge_from_ac, o_charge_from_usb}, 8'h01);
      i_usb_charge_allowed = 0;
      #32;
      chk(o_charge_from_usb, 8'h00);
      w(8'h0D, 8'hFB);
      chk({o_core_rail_en, o_core_rail_discharge, o_vibrator_drive}, 8'h03);
      w(8'h0C, 8'hD1);
      chk({o_low_power_mode, o_core_rail_code}, 8'h07);
      w(8'h0C, 8'hCD);
      chk({o_wait_mode, o_main_rail_en, o_main_rail_code}, 8'h09);
      chk({o_main_rail_discharge, o_core_rail_discharge}, 8'h03);
      rchk(8'h0C, 8'hCD);
      rchk(8'h0D, 8'hFB);
      w(8'h08, 8'h80);
      chk(o_charge_status_oe, 8'h00);
      w(8'h09, 8'h80);
      chk(o_charge_status_oe, 8'h01);
      w(8'h08, 8'h00);
      cnt(80);
      chk(8'(h1), 8'h08);
      w(8'h0A, 8'h82);
      chk(o_indicator2_oe, 8'h00);
      w(8'h0B, 8'h81);
      chk(o_indicator2_oe, 8'h01);
      w(8'h0A, 8'h02);
      cnt(160);
      chk(8'(h2), 8'h18);
      i_main_default_strap = 0;
      i_core_default_strap = 0;
      i_sys_rst = 1;
      repeat (10) @(posedge i_sys_clk);
      #1 i_sys_rst = 0;
      rchk(8'h0C, 8'h32);
      rchk(8'h0D, 8'h68);
      chk({o_main_rail_code, o_core_rail_code}, 8'h16);
      final_report;
   end
endmodule
